/* File: hdl/tlvi_pkg.sv */
// Constants, types and functions of the interrupt controller
package tlvi_pkg;

    // ------------------------------------------------------------
    // Special-function register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_EN_PRI  = 8'hA8;   // irq_enable_primary
    localparam logic [7:0] ADDR_LVL_PRI = 8'hB8;   // irq_level_primary
    localparam logic [7:0] ADDR_EN_EXT  = 8'hE6;   // irq_enable_extended
    localparam logic [7:0] ADDR_LVL_EXT = 8'hF6;   // irq_level_extended

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_GATE  = 7;                   // global_irq_gate
    localparam int BIT_EXT1  = 6;
    localparam int BIT_TMR3  = 5;
    localparam int BIT_SER   = 4;
    localparam int BIT_TICK  = 3;
    localparam int BIT_TMR2  = 1;
    localparam int BIT_EXT0  = 0;
    localparam int BIT_FREQ  = 2;                   // Extended registers
    localparam int BIT_SOFT0 = 3;
    localparam int BIT_SOFT1 = 4;

    // ------------------------------------------------------------
    // Reset values and access masks
    // ------------------------------------------------------------
    localparam logic [7:0] EN_PRI_RST  = 8'h00;
    localparam logic [7:0] LVL_PRI_RST = 8'h00;
    localparam logic [7:0] EN_EXT_RST  = 8'h00;
    localparam logic [7:0] LVL_EXT_RST = 8'h00;
    localparam logic [7:0] LVL_PRI_WMASK = 8'h7F;   // Top bit is fixed
    localparam logic [7:0] LVL_PRI_RDSET = 8'h80;   // Top bit reads one
    localparam logic [7:0] EXT_WMASK     = 8'h1C;   // Bits 4:2 only
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------
    // Source slots in fixed arbitration order
    // ------------------------------------------------------------
    localparam int NUM_SRC    = 12;
    localparam int SLOT_EXT0  = 0;
    localparam int SLOT_TMR2  = 1;
    localparam int SLOT_TICK  = 3;
    localparam int SLOT_SER   = 4;
    localparam int SLOT_TMR3  = 5;
    localparam int SLOT_EXT1  = 6;
    localparam int SLOT_FREQ  = 9;
    localparam int SLOT_SOFT0 = 10;
    localparam int SLOT_SOFT1 = 11;
    localparam logic [11:0] SLOT_RESERVED = 12'h184; // Slots 2, 7 and 8

    // ------------------------------------------------------------
    // Vectors and timing
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_VEC     = 16'h0000;
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam int          DETECT_CYCLES = 1;
    localparam int          CALL_CYCLES   = 4;

    // Call sequencer states
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CALL = 1'b1
    } tlvi_state_t;

    // Lowest set bit index, the fixed-order winner
    function automatic logic [3:0] firstSet(input logic [11:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
                r = 4'(i);
        end
        return r;
    endfunction

    // Service address of a slot, eight bytes apart
    function automatic logic [15:0] vecAddr(input logic [3:0] idx);
        return VEC_BASE + {9'h000, idx, 3'h0};
    endfunction

endpackage

/* File: hdl/tlvi_arb_if.sv */
// Controller to arbiter signals
`timescale 1ns/1ps
interface tlvi_arb_if;
    logic [11:0] req;
    logic [11:0] high;
    logic        winValid;
    logic [3:0]  winIdx;
    logic        winHigh;

    // Controller drives requests and levels
    modport ctrl (output req, output high, input winValid, input winIdx, input winHigh);
    // Arbiter returns the winner
    modport arb  (input req, input high, output winValid, output winIdx, output winHigh);
endinterface

/* File: hdl/tlvi_arbiter.sv */
// Two-level fixed-order arbiter
`timescale 1ns/1ps
module tlvi_arbiter
(
    // Requests in, winner out
    tlvi_arb_if.arb arb
);

    logic [11:0] reqHigh;
    logic [11:0] reqLow;

    // ------------------------------------------------------------
    // Level first, then lowest slot number
    // ------------------------------------------------------------
    always_comb
    begin
        reqHigh      = arb.req & arb.high & ~tlvi_pkg::SLOT_RESERVED;
        reqLow       = arb.req & ~arb.high & ~tlvi_pkg::SLOT_RESERVED;
        arb.winValid = |(reqHigh | reqLow);
        arb.winHigh  = |reqHigh;
        if (|reqHigh)
            arb.winIdx = tlvi_pkg::firstSet(reqHigh);
        else
            arb.winIdx = tlvi_pkg::firstSet(reqLow);
    end

endmodule // tlvi_arbiter

/* File: hdl/tlvi_ctrl.sv */
// Two-level vectored interrupt controller top
//
// Notes on behaviour
// - Nine sources in twelve slots, each with vector, enable and level bit.
// - Software-set flags request like hardware events.
// - High requests preempt low routines; nothing preempts a high routine.
// - One level bit per source, primary or extended register.
// - All sources start at low level after reset.
// - Ties: high level first, then fixed order.
// - Lowest slot number wins; vectors from 0x0003.
// - Clock tick is slot 3, vector 0x001B, enable and level bit 3.
// - Sampled every clock; one detect cycle plus four call cycles.
// - Fetch stalls lengthen the call.
// - After a return, one instruction completes before the next call.
// - Equal or lower level waits for return plus one instruction.
// - Global gate bit 7 blocks all sources when zero.
// - Enable bits: ext1 6, timer3 5, serializer 4, tick 3, timer2 1, ext0 0.
// - Timer 3 requests on either overflow flag.
// - Flags set regardless of enable; disabled flags are ignored.
// - Requests held while gate is zero are serviced once it returns.
// - Vectoring never clears a flag; software does.
// - A flag still set after return raises a fresh request.
`timescale 1ns/1ps
module tlvi_ctrl
#(
    parameter int CALL_CYCLES = tlvi_pkg::CALL_CYCLES
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,

    // Special-function register port
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrite,
    input  wire logic [7:0]  sfrWrData,
    output logic      [7:0]  sfrRdData,

    // Pending flags from peripherals, same clock
    input  wire logic        extEdge0Flag,
    input  wire logic        timerTwoLowFlag,
    input  wire logic        timerTwoHighFlag,
    input  wire logic        clockTickFlag,
    input  wire logic        serializerFlag,
    input  wire logic        timerThreeLowOverflow,
    input  wire logic        timerThreeHighOverflow,
    input  wire logic        extEdge1Flag,
    input  wire logic        freqCountFlag,
    input  wire logic        softSource0Flag,
    input  wire logic        softSource1Flag,

    // Processor core status
    input  wire logic        coreInstrDone,
    input  wire logic        coreReturnDone,
    input  wire logic        coreFetchStall,

    // Call request and service state to the core
    output logic             irqCall,
    output logic      [15:0] irqVector,
    output logic             irqHigh,
    output logic             irqPending,
    output logic             svcLowActive,
    output logic             svcHighActive,
    output logic             globalIrqGate
);

    localparam int CNT_W = $clog2(CALL_CYCLES + 1);
    localparam logic [CNT_W-1:0] CALL_LOAD = CNT_W'(CALL_CYCLES);
    localparam logic [CNT_W-1:0] CALL_LAST = CNT_W'(1);

    // Refuse settings the sequencer cannot serve
    initial
    begin
        if (CALL_CYCLES < 1)
            $error("CALL_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tlvi_arb_if arbBus ();

    logic [7:0]  enPrimary_ff,   nxt_enPrimary;
    logic [6:0]  lvlPrimary_ff,  nxt_lvlPrimary;
    logic [7:0]  enExtended_ff,  nxt_enExtended;
    logic [7:0]  lvlExtended_ff, nxt_lvlExtended;
    logic [7:0]  rdData_ff,      nxt_rdData;

    logic        candValid_ff,   nxt_candValid;
    logic [3:0]  candIdx_ff,     nxt_candIdx;
    logic        candHigh_ff,    nxt_candHigh;

    tlvi_pkg::tlvi_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] callCnt_ff, nxt_callCnt;
    logic        call_ff,        nxt_call;
    logic [15:0] vector_ff,      nxt_vector;
    logic        high_ff,        nxt_high;
    logic        svcLow_ff,      nxt_svcLow;
    logic        svcHigh_ff,     nxt_svcHigh;

    logic [11:0] flags;
    logic [11:0] enables;
    logic [11:0] levels;
    logic        take;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------

    // Writes; level bit 7 and extended bits outside 4:2 held, primary bit 2 written
    always_comb
    begin
        nxt_enPrimary   = enPrimary_ff;
        nxt_lvlPrimary  = lvlPrimary_ff;
        nxt_enExtended  = enExtended_ff;
        nxt_lvlExtended = lvlExtended_ff;
        if (sfrWrite)
        begin
            unique case (sfrAddr)
                tlvi_pkg::ADDR_EN_PRI:  nxt_enPrimary   = sfrWrData;
                tlvi_pkg::ADDR_LVL_PRI: nxt_lvlPrimary  =
                    sfrWrData[6:0] & tlvi_pkg::LVL_PRI_WMASK[6:0];
                tlvi_pkg::ADDR_EN_EXT:  nxt_enExtended  = sfrWrData & tlvi_pkg::EXT_WMASK;
                tlvi_pkg::ADDR_LVL_EXT: nxt_lvlExtended = sfrWrData & tlvi_pkg::EXT_WMASK;
                default:                nxt_enPrimary   = enPrimary_ff;
            endcase
        end
    end

    // Read data, one cycle after address
    always_comb
    begin
        unique case (sfrAddr)
            tlvi_pkg::ADDR_EN_PRI:  nxt_rdData = enPrimary_ff;
            tlvi_pkg::ADDR_LVL_PRI: nxt_rdData = tlvi_pkg::LVL_PRI_RDSET | {1'b0, lvlPrimary_ff};
            tlvi_pkg::ADDR_EN_EXT:  nxt_rdData = enExtended_ff;
            tlvi_pkg::ADDR_LVL_EXT: nxt_rdData = lvlExtended_ff;
            default:                nxt_rdData = tlvi_pkg::RD_UNMAPPED;
        endcase
    end

    // Register storage
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enPrimary_ff   <= tlvi_pkg::EN_PRI_RST;
            lvlPrimary_ff  <= tlvi_pkg::LVL_PRI_RST[6:0];
            enExtended_ff  <= tlvi_pkg::EN_EXT_RST;
            lvlExtended_ff <= tlvi_pkg::LVL_EXT_RST;
            rdData_ff      <= tlvi_pkg::RD_UNMAPPED;
        end
        else
        begin
            enPrimary_ff   <= nxt_enPrimary;
            lvlPrimary_ff  <= nxt_lvlPrimary;
            enExtended_ff  <= nxt_enExtended;
            lvlExtended_ff <= nxt_lvlExtended;
            rdData_ff      <= nxt_rdData;
        end
    end

    // ------------------------------------------------------------
    // Source mapping and gating
    // ------------------------------------------------------------

    // Sources placed in fixed-order slots
    always_comb
    begin
        flags   = 12'h000;
        enables = 12'h000;
        levels  = 12'h000;
        flags[tlvi_pkg::SLOT_EXT0]    = extEdge0Flag;
        flags[tlvi_pkg::SLOT_TMR2]    = timerTwoLowFlag | timerTwoHighFlag;
        flags[tlvi_pkg::SLOT_TICK]    = clockTickFlag;
        flags[tlvi_pkg::SLOT_SER]     = serializerFlag;
        flags[tlvi_pkg::SLOT_TMR3]    = timerThreeLowOverflow | timerThreeHighOverflow;
        flags[tlvi_pkg::SLOT_EXT1]    = extEdge1Flag;
        flags[tlvi_pkg::SLOT_FREQ]    = freqCountFlag;
        flags[tlvi_pkg::SLOT_SOFT0]   = softSource0Flag;
        flags[tlvi_pkg::SLOT_SOFT1]   = softSource1Flag;
        enables[tlvi_pkg::SLOT_EXT0]  = enPrimary_ff[tlvi_pkg::BIT_EXT0];
        enables[tlvi_pkg::SLOT_TMR2]  = enPrimary_ff[tlvi_pkg::BIT_TMR2];
        enables[tlvi_pkg::SLOT_TICK]  = enPrimary_ff[tlvi_pkg::BIT_TICK];
        enables[tlvi_pkg::SLOT_SER]   = enPrimary_ff[tlvi_pkg::BIT_SER];
        enables[tlvi_pkg::SLOT_TMR3]  = enPrimary_ff[tlvi_pkg::BIT_TMR3];
        enables[tlvi_pkg::SLOT_EXT1]  = enPrimary_ff[tlvi_pkg::BIT_EXT1];
        enables[tlvi_pkg::SLOT_FREQ]  = enExtended_ff[tlvi_pkg::BIT_FREQ];
        enables[tlvi_pkg::SLOT_SOFT0] = enExtended_ff[tlvi_pkg::BIT_SOFT0];
        enables[tlvi_pkg::SLOT_SOFT1] = enExtended_ff[tlvi_pkg::BIT_SOFT1];
        levels[tlvi_pkg::SLOT_EXT0]   = lvlPrimary_ff[tlvi_pkg::BIT_EXT0];
        levels[tlvi_pkg::SLOT_TMR2]   = lvlPrimary_ff[tlvi_pkg::BIT_TMR2];
        levels[tlvi_pkg::SLOT_TICK]   = lvlPrimary_ff[tlvi_pkg::BIT_TICK];
        levels[tlvi_pkg::SLOT_SER]    = lvlPrimary_ff[tlvi_pkg::BIT_SER];
        levels[tlvi_pkg::SLOT_TMR3]   = lvlPrimary_ff[tlvi_pkg::BIT_TMR3];
        levels[tlvi_pkg::SLOT_EXT1]   = lvlPrimary_ff[tlvi_pkg::BIT_EXT1];
        levels[tlvi_pkg::SLOT_FREQ]   = lvlExtended_ff[tlvi_pkg::BIT_FREQ];
        levels[tlvi_pkg::SLOT_SOFT0]  = lvlExtended_ff[tlvi_pkg::BIT_SOFT0];
        levels[tlvi_pkg::SLOT_SOFT1]  = lvlExtended_ff[tlvi_pkg::BIT_SOFT1];
    end

    // Masked flags wait in the peripherals
    assign arbBus.req  = flags & enables & {12{enPrimary_ff[tlvi_pkg::BIT_GATE]}};
    assign arbBus.high = levels;

    // Arbiter by level then order
    tlvi_arbiter u_arbiter
    (
        .arb (arbBus.arb)
    );

    // ------------------------------------------------------------
    // Detection stage
    // ------------------------------------------------------------

    // Winner sampled every clock, one detect cycle
    always_comb
    begin
        nxt_candValid = arbBus.winValid;
        nxt_candIdx   = arbBus.winIdx;
        nxt_candHigh  = arbBus.winHigh;
    end

    // Detection registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            candValid_ff <= 1'b0;
            candIdx_ff   <= 4'h0;
            candHigh_ff  <= 1'b0;
        end
        else
        begin
            candValid_ff <= nxt_candValid;
            candIdx_ff   <= nxt_candIdx;
            candHigh_ff  <= nxt_candHigh;
        end
    end

    // ------------------------------------------------------------
    // Acceptance, call sequencing and nesting
    // ------------------------------------------------------------

    // Taken at an instruction boundary; a return is no boundary
    assign take = (state_ff == tlvi_pkg::ST_IDLE) && coreInstrDone && candValid_ff
                  && !svcHigh_ff
                  && (!svcLow_ff || candHigh_ff);

    // Call counter, vector, and two-deep level stack
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_callCnt = callCnt_ff;
        nxt_vector  = vector_ff;
        nxt_high    = high_ff;
        nxt_svcLow  = svcLow_ff;
        nxt_svcHigh = svcHigh_ff;
        // Pop the innermost level on return
        if (coreReturnDone)
        begin
            if (svcHigh_ff)
                nxt_svcHigh = 1'b0;
            else
                nxt_svcLow  = 1'b0;
        end
        unique case (state_ff)
            tlvi_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    nxt_state   = tlvi_pkg::ST_CALL;
                    nxt_callCnt = CALL_LOAD;
                    nxt_vector  = tlvi_pkg::vecAddr(candIdx_ff);
                    nxt_high    = candHigh_ff;
                    if (candHigh_ff)
                        nxt_svcHigh = 1'b1;
                    else
                        nxt_svcLow  = 1'b1;
                end
            end
            tlvi_pkg::ST_CALL:
            begin
                // Flags are left alone; software clears them
                if (!coreFetchStall)
                begin
                    if (callCnt_ff == CALL_LAST)
                        nxt_state = tlvi_pkg::ST_IDLE;
                    else
                        nxt_callCnt = callCnt_ff - CALL_LAST;
                end
            end
        endcase
        nxt_call = (nxt_state == tlvi_pkg::ST_CALL);
    end

    // Sequencer and nesting registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff   <= tlvi_pkg::ST_IDLE;
            callCnt_ff <= '0;
            call_ff    <= 1'b0;
            vector_ff  <= tlvi_pkg::RESET_VEC;
            high_ff    <= 1'b0;
            svcLow_ff  <= 1'b0;
            svcHigh_ff <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            callCnt_ff <= nxt_callCnt;
            call_ff    <= nxt_call;
            vector_ff  <= nxt_vector;
            high_ff    <= nxt_high;
            svcLow_ff  <= nxt_svcLow;
            svcHigh_ff <= nxt_svcHigh;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // All outputs straight from flip-flops
    assign sfrRdData     = rdData_ff;
    assign irqCall       = call_ff;
    assign irqVector     = vector_ff;
    assign irqHigh       = high_ff;
    assign irqPending    = candValid_ff;
    assign svcLowActive  = svcLow_ff;
    assign svcHighActive = svcHigh_ff;
    assign globalIrqGate = enPrimary_ff[tlvi_pkg::BIT_GATE];

endmodule // tlvi_ctrl

/* File: testbench/tlvi_ctrl_asserts.sv */
// Port checker for the interrupt controller
`timescale 1ns/1ps
module tlvi_ctrl_asserts
#(
    parameter int CALL_CYCLES = 4
)
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Core status
    input wire logic        coreInstrDone,
    input wire logic        coreReturnDone,
    input wire logic        coreFetchStall,
    // Controller outputs
    input wire logic        irqCall,
    input wire logic [15:0] irqVector,
    input wire logic        irqHigh,
    input wire logic        irqPending,
    input wire logic        svcLowActive,
    input wire logic        svcHighActive,
    input wire logic        globalIrqGate
);
    logic [3:0] callCnt_ff;
    logic [3:0] nxt_callCnt;

    // Counts unstalled call cycles
    always_comb
    begin
        nxt_callCnt = irqCall ? callCnt_ff + {3'h0, !coreFetchStall} : 4'h0;
    end

    // Count register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            callCnt_ff <= 4'h0;
        else
            callCnt_ff <= nxt_callCnt;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Call body and acceptance condition
    sequence s_callBody;
        irqCall [*4];
    endsequence
    sequence s_accept;
        irqPending && coreInstrDone && !irqCall && !svcLowActive && !svcHighActive;
    endsequence

    property p_callMin; $rose(irqCall) |-> s_callBody; endproperty
    property p_callLen; $fell(irqCall) |-> callCnt_ff == 4'(CALL_CYCLES); endproperty
    property p_latency; s_accept |=> $rose(irqCall); endproperty
    property p_gate; !globalIrqGate |=> !irqPending; endproperty
    property p_vec;
        $rose(irqCall) |-> irqVector[2:0] == 3'h3 && irqVector <= 16'h005B
            && !(irqVector inside {16'h0013, 16'h003B, 16'h0043});
    endproperty
    property p_push; $rose(irqCall) |-> (irqHigh ? svcHighActive : svcLowActive); endproperty
    property p_highHold;
        svcHighActive && !coreReturnDone |=> svcHighActive && !$rose(irqCall);
    endproperty
    property p_lowWait; svcLowActive && !svcHighActive |=> !$rose(irqCall) || irqHigh; endproperty
    property p_retGap; coreReturnDone |=> !$rose(irqCall); endproperty

    a_callMin: assert property (p_callMin) else $error("call too short");
    a_callLen: assert property (p_callLen) else $error("call length wrong");
    a_latency: assert property (p_latency) else $error("no call after detect");
    a_gate: assert property (p_gate) else $error("request passed closed gate");
    a_vec: assert property (p_vec) else $error("bad vector");
    a_push: assert property (p_push) else $error("nesting not pushed");
    a_highHold: assert property (p_highHold) else $error("high routine preempted");
    a_lowWait: assert property (p_lowWait) else $error("low routine preempted by low");
    a_retGap: assert property (p_retGap) else $error("call right after return");
endmodule // tlvi_ctrl_asserts

bind tlvi_ctrl tlvi_ctrl_asserts #(.CALL_CYCLES(CALL_CYCLES)) u_chk
(
    .mclk, .rst_n, .coreInstrDone, .coreReturnDone, .coreFetchStall, .irqCall, .irqVector,
    .irqHigh, .irqPending, .svcLowActive, .svcHighActive, .globalIrqGate
);

/* File: testbench/tlvi_core_model.sv */
// Processor core model
`timescale 1ns/1ps
module tlvi_core_model
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Bench controls
    input  wire logic retReq,
    input  wire logic stallReq,
    input  wire logic slowMode,
    // Call from the controller
    input  wire logic irqCall,
    // Status to the controller
    output logic      coreInstrDone,
    output logic      coreReturnDone,
    output logic      coreFetchStall
);
    logic phase_ff;

    // Slow mode retires every other cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            phase_ff <= 1'b0;
        else
            phase_ff <= !phase_ff;
    end

    // Nothing retires during a call or a return
    assign coreInstrDone  = rst_n && !irqCall && !retReq && (!slowMode || phase_ff);
    assign coreReturnDone = rst_n && retReq && !irqCall;
    assign coreFetchStall = irqCall && stallReq;
endmodule // tlvi_core_model

/* File: testbench/tlvi_ctrl_test.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tlvi_ctrl_test;
    logic        mclk, rst_n, sfrWrite, retReq, stallReq, slowMode;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData;
    logic [10:0] flags;
    logic        coreInstrDone, coreReturnDone, coreFetchStall, irqCall, irqHigh;
    logic        irqPending, svcLowActive, svcHighActive, globalIrqGate;
    logic [15:0] irqVector;
    int          errTotal, testsRun, n, lat, len;
    int          slotTab [11] = '{0, 1, 1, 3, 4, 5, 5, 6, 9, 10, 11};
    int          bitTab  [11] = '{0, 1, 1, 3, 4, 5, 5, 6, 2, 3, 4};

    // Design and core model
    tlvi_ctrl u_dut
    (
        .mclk, .rst_n, .sfrAddr, .sfrWrite, .sfrWrData, .sfrRdData,
        .extEdge0Flag(flags[0]), .timerTwoLowFlag(flags[1]), .timerTwoHighFlag(flags[2]),
        .clockTickFlag(flags[3]), .serializerFlag(flags[4]), .timerThreeLowOverflow(flags[5]),
        .timerThreeHighOverflow(flags[6]), .extEdge1Flag(flags[7]), .freqCountFlag(flags[8]),
        .softSource0Flag(flags[9]), .softSource1Flag(flags[10]),
        .coreInstrDone, .coreReturnDone, .coreFetchStall, .irqCall, .irqVector, .irqHigh,
        .irqPending, .svcLowActive, .svcHighActive, .globalIrqGate
    );
    tlvi_core_model u_core
    (
        .mclk, .rst_n, .retReq, .stallReq, .slowMode, .irqCall,
        .coreInstrDone, .coreReturnDone, .coreFetchStall
    );

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // Compare and access tasks
    // ----------------------------------------
    task automatic chkVec(input string nm, input logic [15:0] e, input logic [15:0] g);
        testsRun++;
        if (g !== e)
        begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, input logic g);
        chkVec(nm, 16'(e), 16'(g));
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfrAddr   <= a;
        sfrWrite  <= 1'b1;
        sfrWrData <= d;
        @(posedge mclk);
        sfrWrite  <= 1'b0;
    endtask
    task automatic regCheck(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        sfrAddr <= a;
        @(posedge mclk);
        #1 chkVec("register", 16'(e), 16'(sfrRdData));
    endtask
    // Waits for a call, checks it, times it
    task automatic takeCall(input logic [15:0] v, input logic h);
        n = 0;
        while (irqCall !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            #1 n++;
        end
        lat = n;
        chkBit("call", 1'b1, irqCall);
        chkVec("vector", v, irqVector);
        chkBit("level", h, irqHigh);
        len = 0;
        while (irqCall === 1'b1 && len < 40)
        begin
            @(posedge mclk);
            #1 len++;
        end
    endtask
    // Routine clears flags and returns
    task automatic endService(input logic [10:0] keep);
        @(posedge mclk);
        flags  <= flags & keep;
        retReq <= 1'b1;
        @(posedge mclk);
        retReq <= 1'b0;
    endtask
    task automatic completeRun();
        $display("comparisons %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (6000) @(posedge mclk);
        errTotal++;
        $display("[ERR] watchdog expected end seen hang");
        completeRun();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        {errTotal, testsRun} = '0;
        {rst_n, sfrWrite, retReq, stallReq, slowMode} = '0;
        {sfrAddr, sfrWrData, flags} = '0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        chkVec("reset vector", 16'h0000, irqVector);
        regCheck(8'hA8, 8'h00);
        regCheck(8'hB8, 8'h80);
        regCheck(8'hF6, 8'h00);
        regWrite(8'hB8, 8'h7B);
        regCheck(8'hB8, 8'hFB);
        regWrite(8'hF6, 8'hFF);
        regCheck(8'hF6, 8'h1C);
        regWrite(8'h55, 8'hFF);
        regCheck(8'h55, 8'h00);
        regWrite(8'hA8, 8'hFB);
        regCheck(8'hA8, 8'hFB);
        chkBit("gate", 1'b1, globalIrqGate);
        regWrite(8'hB8, 8'h00);
        regWrite(8'hF6, 8'h00);
        $display("test registers done");
        regWrite(8'hA8, 8'h01);
        flags <= 11'h001;
        repeat (8) @(posedge mclk);
        #1 chkBit("pending", 1'b0, irqPending);
        regWrite(8'hA8, 8'h81);
        takeCall(16'h0003, 1'b0);
        endService(11'h7FF);
        takeCall(16'h0003, 1'b0);
        chkVec("return delay", 16'h0001, 16'(lat));
        endService(11'h000);
        flags <= 11'h001;
        takeCall(16'h0003, 1'b0);
        chkVec("latency", 16'h0002, 16'(lat));
        chkVec("length", 16'h0004, 16'(len));
        endService(11'h000);
        flags <= 11'h001;
        repeat (3) @(posedge mclk);
        stallReq <= 1'b1;
        repeat (2) @(posedge mclk);
        stallReq <= 1'b0;
        takeCall(16'h0003, 1'b0);
        chkVec("stalled length", 16'h0003, 16'(len));
        endService(11'h000);
        $display("test gate and latency done");
        for (int i = 0; i < 11; i++)
        begin
            regWrite(8'hA8, 8'h80);
            regWrite(8'hE6, 8'h00);
            flags <= 11'(1 << i);
            repeat (4) @(posedge mclk);
            #1 chkBit("masked", 1'b0, irqCall);
            if (i < 8)
                regWrite(8'hA8, 8'h80 | 8'(1 << bitTab[i]));
            else
                regWrite(8'hE6, 8'(1 << bitTab[i]));
            takeCall(16'h0003 + 16'(slotTab[i] * 8), 1'b0);
            endService(11'h000);
        end
        $display("test sources done");
        regWrite(8'hA8, 8'hFB);
        regWrite(8'hE6, 8'h1C);
        flags <= 11'h7FF;
        takeCall(16'h0003, 1'b0);
        endService(11'h000);
        regWrite(8'hB8, 8'h18);
        flags <= 11'h7FF;
        takeCall(16'h001B, 1'b1);
        endService(11'h000);
        regWrite(8'hF6, 8'h04);
        regWrite(8'hB8, 8'h00);
        flags <= 11'h7FF;
        takeCall(16'h004B, 1'b1);
        endService(11'h000);
        $display("test arbitration done");
        regWrite(8'hB8, 8'h18);
        slowMode <= 1'b1;
        flags <= 11'h080;
        takeCall(16'h0033, 1'b0);
        flags <= 11'h001;
        repeat (8) @(posedge mclk);
        #1 chkBit("equal level", 1'b0, irqCall);
        flags <= 11'h009;
        takeCall(16'h001B, 1'b1);
        chkBit("high kept", 1'b1, svcHighActive);
        chkBit("low kept", 1'b1, svcLowActive);
        flags <= 11'h019;
        repeat (8) @(posedge mclk);
        #1 chkBit("high nested", 1'b0, irqCall);
        endService(11'h001);
        repeat (8) @(posedge mclk);
        #1 chkBit("low still", 1'b0, irqCall);
        endService(11'h001);
        takeCall(16'h0003, 1'b0);
        endService(11'h000);
        $display("test preemption done");
        completeRun();
    end
endmodule // tlvi_ctrl_test
